/* tcu_pkg.sv */
package tcu_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_T01_CONTROL = 8'h88;
    localparam logic [7:0] IDX_T01_MODE = 8'h89;
    localparam logic [7:0] IDX_T0_LOW = 8'h8A;
    localparam logic [7:0] IDX_T1_LOW = 8'h8B;
    localparam logic [7:0] IDX_T0_HIGH = 8'h8C;
    localparam logic [7:0] IDX_T1_HIGH = 8'h8D;
    localparam logic [7:0] IDX_T2_CONTROL = 8'hC8;
    localparam logic [7:0] IDX_T2_RELOAD_LOW = 8'hCA;
    localparam logic [7:0] IDX_T2_RELOAD_HIGH = 8'hCB;
    localparam logic [7:0] IDX_T2_LOW = 8'hCC;
    localparam logic [7:0] IDX_T2_HIGH = 8'hCD;

    // Address slicing of the bus
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 9;
    localparam int DEC_MSB = 10;

    // Timer 0/1 control bits
    localparam int TIMER01_CONTROL_TF1 = 7;
    localparam int TIMER01_CONTROL_TR1 = 6;
    localparam int TIMER01_CONTROL_TF0 = 5;
    localparam int TIMER01_CONTROL_TR0 = 4;

    // Mode select fields, timer 1 sits one nibble above timer 0
    localparam int TIMER01_MODE_SELECT_MODE_LSB = 0;
    localparam int TIMER01_MODE_SELECT_CT = 2;
    localparam int TIMER01_MODE_SELECT_GATE = 3;
    localparam int TIMER01_MODE_SELECT_T1_BASE = 4;

    // Timer 2 control bits
    localparam int T2_TF2 = 7;
    localparam int T2_THIRD_TIMER_EXTERNAL_FLAG = 6;
    localparam int T2_RCLK = 5;
    localparam int T2_TRANSMIT_CLOCK_SELECT = 4;
    localparam int T2_EXTERNAL_ENABLE_BIT = 3;
    localparam int T2_TR2 = 2;
    localparam int T2_CT2 = 1;
    localparam int T2_CAPTURE_SELECT_BIT = 0;

    // Timer 0/1 mode codes
    localparam logic [1:0] MODE_13BIT = 2'h0;
    localparam logic [1:0] MODE_16BIT = 2'h1;
    localparam logic [1:0] MODE_RELOAD8 = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [15:0] WORD_ONE = 16'h0001;
    localparam logic [12:0] C13_ONE = 13'h0001;

    // Synchronised pin positions
    localparam int PIN_EXTERNAL_INTERRUPT_PIN_ZERO = 0;
    localparam int PIN_INT1 = 1;
    localparam int PIN_CNT0 = 2;
    localparam int PIN_CNT1 = 3;
    localparam int PIN_CNT2 = 4;
    localparam int PIN_TRIG = 5;
    localparam int PIN_COUNT = 6;

    // Captured address phase
    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] index;
    } tcu_bus_req_type;

    // Result of one counting step of timer 0 or 1
    typedef struct packed {
        logic ovf;
        logic [7:0] hi;
        logic [7:0] lo;
    } tcu_step_type;

endpackage

/* tcu_top.sv */
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/100ps
module tcu_top
    import tcu_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [ADDR_WIDTH-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // External pins
    input wire logic external_interrupt_pin_zero_n,
    input wire logic external_interrupt_pin_one_n,
    input wire logic count_pin_zero,
    input wire logic count_pin_one,
    input wire logic external_count_pin,
    input wire logic external_trigger_pin,
    // Flags and overflow pulses for the core
    output logic first_timer_overflow_flag,
    output logic second_timer_overflow_flag,
    output logic third_timer_overflow_flag,
    output logic third_timer_external_flag,
    output logic timer1_overflow_pulse,
    output logic timer2_overflow_pulse
);

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] timer01_control;
    logic [7:0] timer01_mode_select;
    logic [7:0] timer0_count_low;
    logic [7:0] timer0_count_high;
    logic [7:0] timer1_count_low;
    logic [7:0] timer1_count_high;
    logic [7:0] timer2_control;
    logic [7:0] timer2_reload_capture_low;
    logic [7:0] timer2_reload_capture_high;
    logic [7:0] timer2_count_low;
    logic [7:0] timer2_count_high;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and falling edge detection

    logic [PIN_COUNT-1:0] pin_meta;
    logic [PIN_COUNT-1:0] pin_sync;
    logic [PIN_COUNT-1:0] pin_prev;
    wire [PIN_COUNT-1:0] pin_raw;
    wire [PIN_COUNT-1:0] pin_fall;

    assign pin_raw[PIN_EXTERNAL_INTERRUPT_PIN_ZERO] = external_interrupt_pin_zero_n;
    assign pin_raw[PIN_INT1] = external_interrupt_pin_one_n;
    assign pin_raw[PIN_CNT0] = count_pin_zero;
    assign pin_raw[PIN_CNT1] = count_pin_one;
    assign pin_raw[PIN_CNT2] = external_count_pin;
    assign pin_raw[PIN_TRIG] = external_trigger_pin;

    // Two stages before use; a third stage only feeds the edge detector
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
            pin_prev <= '0;
        end
        else
        begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    assign pin_fall = pin_prev & ~pin_sync;

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: writes take no wait, reads take one wait state

    tcu_bus_req_type dp;
    logic rd_stage;
    logic addr_ok_q;
    wire take = hsel & hready & htrans[1];
    wire addr_ok = (haddr[IDX_LSB-1:0] == '0)
        & (haddr[ADDR_WIDTH-1:DEC_MSB] == '0);
    wire wr_en = dp.write & hreadyout;
    wire [7:0] wr_data = hwdata[7:0];
    logic [7:0] rd_mux;

    assign hreadyout = ~(dp.read & ~rd_stage);
    assign hresp = 1'b0;

    // The wait state lets a read see a write made the cycle before
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            dp <= '0;
            rd_stage <= 1'b0;
            hrdata <= '0;
        end
        else if (hreadyout)
        begin
            dp.write <= take & hwrite & addr_ok;
            dp.read <= take & ~hwrite;
            dp.index <= haddr[IDX_MSB:IDX_LSB];
            rd_stage <= 1'b0;
        end
        else
        begin
            hrdata <= {24'h000000, rd_mux};
            rd_stage <= 1'b1;
        end
    end

    // Read selection, unmapped indices read zero
    always_comb
    begin
        rd_mux = REG_RESET;
        if (addr_ok_q)
        begin
            unique case (dp.index)
                IDX_T01_CONTROL: rd_mux = timer01_control;
                IDX_T01_MODE: rd_mux = timer01_mode_select;
                IDX_T0_LOW: rd_mux = timer0_count_low;
                IDX_T1_LOW: rd_mux = timer1_count_low;
                IDX_T0_HIGH: rd_mux = timer0_count_high;
                IDX_T1_HIGH: rd_mux = timer1_count_high;
                IDX_T2_CONTROL: rd_mux = timer2_control;
                IDX_T2_RELOAD_LOW: rd_mux = timer2_reload_capture_low;
                IDX_T2_RELOAD_HIGH: rd_mux = timer2_reload_capture_high;
                IDX_T2_LOW: rd_mux = timer2_count_low;
                IDX_T2_HIGH: rd_mux = timer2_count_high;
                default: rd_mux = REG_RESET;
            endcase
        end
    end

    // Misaligned or out-of-range reads are remembered for the data phase
    always_ff @(posedge mclk)
    begin
        if (reset)
            addr_ok_q <= 1'b0;
        else if (hreadyout)
            addr_ok_q <= addr_ok;
    end

    // Write strobes per register
    wire wr_timer01_control = wr_en & (dp.index == IDX_T01_CONTROL);
    wire wr_timer01_mode_select = wr_en & (dp.index == IDX_T01_MODE);
    wire wr_tl0 = wr_en & (dp.index == IDX_T0_LOW);
    wire wr_tl1 = wr_en & (dp.index == IDX_T1_LOW);
    wire wr_th0 = wr_en & (dp.index == IDX_T0_HIGH);
    wire wr_th1 = wr_en & (dp.index == IDX_T1_HIGH);
    wire wr_timer2_control = wr_en & (dp.index == IDX_T2_CONTROL);
    wire wr_rl2 = wr_en & (dp.index == IDX_T2_RELOAD_LOW);
    wire wr_rh2 = wr_en & (dp.index == IDX_T2_RELOAD_HIGH);
    wire wr_tl2 = wr_en & (dp.index == IDX_T2_LOW);
    wire wr_th2 = wr_en & (dp.index == IDX_T2_HIGH);

    ////////////////////////////////////////////////////////////////////////
    // Timer 0 and 1 controls

    wire [1:0] mode0 = timer01_mode_select[TIMER01_MODE_SELECT_MODE_LSB +: 2];
    wire [1:0] mode1 = timer01_mode_select[TIMER01_MODE_SELECT_T1_BASE+TIMER01_MODE_SELECT_MODE_LSB +: 2];
    wire ct0 = timer01_mode_select[TIMER01_MODE_SELECT_CT];
    wire ct1 = timer01_mode_select[TIMER01_MODE_SELECT_T1_BASE+TIMER01_MODE_SELECT_CT];
    wire first_timer_gate_select = timer01_mode_select[TIMER01_MODE_SELECT_GATE];
    wire gate1 = timer01_mode_select[TIMER01_MODE_SELECT_T1_BASE+TIMER01_MODE_SELECT_GATE];
    wire run0 = timer01_control[TIMER01_CONTROL_TR0];
    wire run1 = timer01_control[TIMER01_CONTROL_TR1];
    wire split0 = (mode0 == MODE_SPLIT);

    // Core cycles feed the timers undivided
    wire src0 = ct0 ? pin_fall[PIN_CNT0] : 1'b1;
    wire src1 = ct1 ? pin_fall[PIN_CNT1] : 1'b1;
    wire go0 = run0 & (~first_timer_gate_select | pin_sync[PIN_EXTERNAL_INTERRUPT_PIN_ZERO]) & src0;
    wire go1 = run1 & (~gate1 | pin_sync[PIN_INT1]) & src1
        & (mode1 != MODE_SPLIT);

    // One counting step of a timer 0/1 pair in the given mode
    function automatic tcu_step_type step(input logic [1:0] mode,
        input logic [7:0] hi, input logic [7:0] lo);
        tcu_step_type r;
        logic [12:0] c13;
        logic [15:0] c16;
        r.hi = hi;
        r.lo = lo;
        r.ovf = 1'b0;
        c13 = {hi, lo[4:0]};
        c16 = {hi, lo};
        unique case (mode)
            MODE_13BIT:
            begin
                r.ovf = &c13;
                c13 = c13 + C13_ONE;
                r.hi = c13[12:5];
                r.lo = {lo[7:5], c13[4:0]};
            end
            MODE_16BIT:
            begin
                r.ovf = &c16;
                c16 = c16 + WORD_ONE;
                {r.hi, r.lo} = c16;
            end
            MODE_RELOAD8:
            begin
                r.ovf = &lo;
                r.lo = r.ovf ? hi : lo + BYTE_ONE;
            end
            MODE_SPLIT:
            begin
                r.ovf = &lo;
                r.lo = lo + BYTE_ONE;
            end
        endcase
        return r;
    endfunction

    wire tcu_step_type st0 = step(mode0, timer0_count_high, timer0_count_low);
    wire tcu_step_type st1 = step(mode1, timer1_count_high, timer1_count_low);

    // Split high byte of timer 0 counts cycles under timer 1's run bit
    wire go0_high = split0 & run1;
    wire ovf0_high = go0_high & (&timer0_count_high);
    wire ovf0 = go0 & st0.ovf;
    wire ovf1 = go1 & st1.ovf;
    wire set_tf1 = split0 ? ovf0_high : ovf1;

    // Next count values; a software write wins over counting
    wire [7:0] next_tl0 = wr_tl0 ? wr_data : go0 ? st0.lo : timer0_count_low;
    wire [7:0] next_th0 = wr_th0 ? wr_data
        : go0_high ? timer0_count_high + BYTE_ONE
        : (go0 & ~split0) ? st0.hi : timer0_count_high;
    wire [7:0] next_tl1 = wr_tl1 ? wr_data : go1 ? st1.lo : timer1_count_low;
    wire [7:0] next_th1 = wr_th1 ? wr_data : go1 ? st1.hi : timer1_count_high;

    // Control write keeps the count registers, flag set wins over clear
    wire [7:0] timer01_control_base = wr_timer01_control ? wr_data : timer01_control;
    wire [7:0] next_timer01_control = timer01_control_base
        | ({7'h00, ovf0} << TIMER01_CONTROL_TF0)
        | ({7'h00, set_tf1} << TIMER01_CONTROL_TF1);

    ////////////////////////////////////////////////////////////////////////
    // Timer 2

    wire run2 = timer2_control[T2_TR2];
    wire baud2 = timer2_control[T2_RCLK] | timer2_control[T2_TRANSMIT_CLOCK_SELECT];
    wire capture_select_bit = timer2_control[T2_CAPTURE_SELECT_BIT] & ~baud2;
    wire src2 = timer2_control[T2_CT2] ? pin_fall[PIN_CNT2] : 1'b1;
    wire go2 = run2 & src2;
    wire [15:0] cnt2 = {timer2_count_high, timer2_count_low};
    wire [15:0] rld2 = {timer2_reload_capture_high,
        timer2_reload_capture_low};
    wire ovf2 = go2 & (&cnt2);
    wire ext2 = run2 & timer2_control[T2_EXTERNAL_ENABLE_BIT]
        & pin_fall[PIN_TRIG];
    wire reload2 = (ovf2 & ~capture_select_bit) | (ext2 & ~capture_select_bit & ~baud2);
    wire capture2 = ext2 & capture_select_bit;
    wire [15:0] step2 = reload2 ? rld2 : go2 ? cnt2 + WORD_ONE : cnt2;

    wire [7:0] next_tl2 = wr_tl2 ? wr_data : step2[7:0];
    wire [7:0] next_th2 = wr_th2 ? wr_data : step2[15:8];
    wire [7:0] next_rl2 = wr_rl2 ? wr_data
        : capture2 ? timer2_count_low : timer2_reload_capture_low;
    wire [7:0] next_rh2 = wr_rh2 ? wr_data
        : capture2 ? timer2_count_high : timer2_reload_capture_high;

    // Flags only set here and only cleared by software
    wire [7:0] timer2_control_base = wr_timer2_control ? wr_data : timer2_control;
    wire [7:0] next_timer2_control = timer2_control_base
        | ({7'h00, ovf2 & ~baud2} << T2_TF2)
        | ({7'h00, ext2} << T2_THIRD_TIMER_EXTERNAL_FLAG);

    ////////////////////////////////////////////////////////////////////////
    // State update

    // All registers clear at reset and load their next values every edge
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            timer01_control <= REG_RESET;
            timer01_mode_select <= REG_RESET;
            timer0_count_low <= REG_RESET;
            timer0_count_high <= REG_RESET;
            timer1_count_low <= REG_RESET;
            timer1_count_high <= REG_RESET;
            timer2_control <= REG_RESET;
            timer2_reload_capture_low <= REG_RESET;
            timer2_reload_capture_high <= REG_RESET;
            timer2_count_low <= REG_RESET;
            timer2_count_high <= REG_RESET;
        end
        else
        begin
            timer01_control <= next_timer01_control;
            timer01_mode_select <= wr_timer01_mode_select ? wr_data : timer01_mode_select;
            timer0_count_low <= next_tl0;
            timer0_count_high <= next_th0;
            timer1_count_low <= next_tl1;
            timer1_count_high <= next_th1;
            timer2_control <= next_timer2_control;
            timer2_reload_capture_low <= next_rl2;
            timer2_reload_capture_high <= next_rh2;
            timer2_count_low <= next_tl2;
            timer2_count_high <= next_th2;
        end
    end

    // Overflow pulses stay available as baud ticks even without flags
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            timer1_overflow_pulse <= 1'b0;
            timer2_overflow_pulse <= 1'b0;
        end
        else
        begin
            timer1_overflow_pulse <= ovf1;
            timer2_overflow_pulse <= ovf2;
        end
    end

    // Flag outputs straight from the control registers
    assign first_timer_overflow_flag = timer01_control[TIMER01_CONTROL_TF0];
    assign second_timer_overflow_flag = timer01_control[TIMER01_CONTROL_TF1];
    assign third_timer_overflow_flag = timer2_control[T2_TF2];
    assign third_timer_external_flag = timer2_control[T2_THIRD_TIMER_EXTERNAL_FLAG];

endmodule

/* tcu_pin_model.sv */
`timescale 1ns/100ps
module tcu_pin_model
(
    // Clock
    input wire logic mclk,
    // Gate, count and trigger pins
    output logic [5:0] pins
);
    //////////////////////////////////////////////////////////////////
    // All lines idle high, so no stray falling edge at start
    initial pins = 6'h3F;
    // Low long enough to pass the three-stage synchroniser
    task automatic pulse(input int k);
        pins[k] <= 1'b0;
        repeat (4) @(posedge mclk);
        pins[k] <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask
    // Level change for a gate pin
    task automatic level(input int k, input logic v);
        pins[k] <= v;
        @(posedge mclk);
    endtask
endmodule

/* tcu_props.sv */
`timescale 1ns/100ps
module tcu_props
    import tcu_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Bus
    input wire logic hsel,
    input wire logic [ADDR_WIDTH-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Timer 2 flags and pulse
    input wire logic third_timer_overflow_flag,
    input wire logic third_timer_external_flag,
    input wire logic timer2_overflow_pulse
);
    logic rd_q;
    logic wr_q;
    logic baud_q;
    logic [7:0] idx_q;
    //////////////////////////////////////////////////////////////////
    // Data phase tracking; a shadow of the baud bits judges TF2
    wire taken = hsel & hready & htrans[1];
    wire wr_t2 = wr_q & hready & (idx_q == IDX_T2_CONTROL);
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            baud_q <= 1'b0;
        end
        else if (hready)
        begin
            rd_q <= taken & ~hwrite;
            wr_q <= taken & hwrite;
            idx_q <= haddr[IDX_MSB:IDX_LSB];
            if (wr_t2)
                baud_q <= hwdata[T2_RCLK] | hwdata[T2_TRANSMIT_CLOCK_SELECT];
        end
    end
    //////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    // Bus answers
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("response not OKAY");
    read_wait_a: assert property (taken && !hwrite |=>
        !hreadyout ##1 hreadyout) else $error("read wait wrong");
    write_fast_a: assert property (taken && hwrite |=> hreadyout)
        else $error("write stalled");
    rdata_upper_a: assert property (rd_q && hreadyout |->
        hrdata[31:8] == 24'h0) else $error("read upper bits set");
    rdata_hold_a: assert property ($changed(hrdata) |->
        $past(rd_q & ~hreadyout)) else $error("read data moved");
    // Timer 2 flags: only software clears, baud never sets overflow
    tf2_clear_a: assert property (
        $fell(third_timer_overflow_flag) |-> $past(wr_t2))
        else $error("overflow flag cleared by hardware");
    third_timer_external_flag_clear_a: assert property (
        $fell(third_timer_external_flag) |-> $past(wr_t2))
        else $error("external flag cleared by hardware");
    baud_no_tf2_a: assert property (
        $rose(third_timer_overflow_flag) && !$past(wr_t2) |->
        !$past(baud_q)) else $error("overflow flag in baud mode");
    cover property (taken && !hwrite);
    cover property ($rose(third_timer_external_flag));
    cover property ($rose(timer2_overflow_pulse) && baud_q);
endmodule
bind tcu_top tcu_props #(.ADDR_WIDTH(ADDR_WIDTH)) i_tcu_props (
    .mclk, .reset, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .third_timer_overflow_flag,
    .third_timer_external_flag, .timer2_overflow_pulse
);

/* three_timer_counter_unit_tb.sv */
`timescale 1ns/100ps
module three_timer_counter_unit_tb
    import tcu_pkg::*;
();
    logic mclk;
    logic reset;
    logic hwrite;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [31:0] seed = 32'h14;
    wire [5:0] pins;
    wire [5:0] flg;
    int err_count = 0;
    int n_checks = 0;
    logic [7:0] idx [11] = '{IDX_T01_CONTROL, IDX_T01_MODE, IDX_T0_LOW,
        IDX_T1_LOW, IDX_T0_HIGH, IDX_T1_HIGH, IDX_T2_CONTROL,
        IDX_T2_RELOAD_LOW, IDX_T2_RELOAD_HIGH, IDX_T2_LOW, IDX_T2_HIGH};
    //////////////////////////////////////////////////////////////////
    tcu_top i_tcu_top (
        .mclk, .reset, .hsel(1'b1), .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .external_interrupt_pin_zero_n(pins[PIN_EXTERNAL_INTERRUPT_PIN_ZERO]),
        .external_interrupt_pin_one_n(pins[PIN_INT1]),
        .count_pin_zero(pins[PIN_CNT0]), .count_pin_one(pins[PIN_CNT1]),
        .external_count_pin(pins[PIN_CNT2]),
        .external_trigger_pin(pins[PIN_TRIG]),
        .first_timer_overflow_flag(flg[0]),
        .second_timer_overflow_flag(flg[1]),
        .third_timer_overflow_flag(flg[2]),
        .third_timer_external_flag(flg[3]),
        .timer1_overflow_pulse(flg[4]), .timer2_overflow_pulse(flg[5])
    );
    tcu_pin_model i_tcu_pin_model (.mclk, .pins);
    // Free-running core clock
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    //////////////////////////////////////////////////////////////////
    // Xorshift source, repeatable from its fixed start
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // High byte after one overflow of the low side
    function automatic logic [7:0] hi_after(int m, logic [7:0] rl);
        return (m == 2) ? rl : (m == 3) ? 8'hFF : 8'h00;
    endfunction
    task automatic chk(logic [15:0] got, logic [15:0] exp, string s);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t %s: got %h expected %h", $time, s, got, exp);
        end
    endtask
    // Sampled at the falling edge so the result never races the flops
    task automatic wait_rdy(output logic [7:0] d);
        logic r;
        int n;
        n = 0;
        do
        begin
            @(negedge mclk);
            r = hreadyout;
            d = hrdata[7:0];
            @(posedge mclk);
            n++;
        end
        while (!r && n < 9);
        chk(r, 1'b1, "bus answer");
    endtask
    task automatic xfer(logic w, logic [7:0] a, logic [7:0] wd,
        output logic [7:0] rd);
        htrans <= 2'h2;
        haddr <= {2'h0, a, 2'h0};
        hwrite <= w;
        wait_rdy(rd);
        htrans <= 2'h0;
        hwdata <= {rnd(), rnd(), rnd(), wd};
        wait_rdy(rd);
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        logic [7:0] x;
        xfer(1'b1, a, d, x);
    endtask
    task automatic rd_chk(logic [7:0] a, logic [7:0] e);
        logic [7:0] x;
        xfer(1'b0, a, 8'h00, x);
        chk(x, e, "register read");
    endtask
    // Cycles until a flag or pulse shows, bounded by lim
    task automatic wait_flag(int k, int lim, output int n, output logic v);
        n = 0;
        forever
        begin
            @(negedge mclk);
            v = flg[k];
            if (v === 1'b1 || n > lim)
                break;
            @(posedge mclk);
            n++;
        end
        @(posedge mclk);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////
    // Watchdog at 20000 cycles, well past the expected run of under a thousand cycles
    initial
    begin
        #400000;
        err_count++;
        give_verdict();
    end
    // Main sequence
    initial
    begin
        int k;
        int n;
        logic v;
        logic [7:0] r;
        logic [7:0] q;
        reset = 1'b1;
        htrans = 2'h0;
        haddr = 12'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        foreach (idx[i]) rd_chk(idx[i], 8'h00);
        foreach (idx[i])
            if (i != 0 && i != 6)
            begin
                r = rnd();
                wr(idx[i], r);
                rd_chk(idx[i], r);
            end
        wr(8'h8E, 8'hA5);
        rd_chk(8'h8E, 8'h00);
        $display("register test done");
        // Timer 0 in every mode, preset just short of rollover
        for (int m = 0; m < 4; m++)
        begin
            k = 1 + rnd() % 20;
            r = rnd() & 8'h7F;
            wr(IDX_T01_MODE, 8'(m));
            wr(IDX_T0_LOW, 8'hFF - 8'(k));
            wr(IDX_T0_HIGH, (m == 2) ? r : 8'hFF);
            wr(IDX_T01_CONTROL, 8'h10);
            wait_flag(0, 40, n, v);
            chk(16'(n), 16'(k + 1), "overflow time");
            wr(IDX_T01_CONTROL, 8'h00);
            rd_chk(IDX_T0_HIGH, hi_after(m, r));
        end
        $display("mode test done");
        wr(IDX_T01_MODE, 8'h09);
        wr(IDX_T0_LOW, 8'hF0);
        wr(IDX_T0_HIGH, 8'hFF);
        i_tcu_pin_model.level(PIN_EXTERNAL_INTERRUPT_PIN_ZERO, 1'b0);
        wr(IDX_T01_CONTROL, 8'h10);
        wait_flag(0, 30, n, v);
        chk(v, 1'b0, "gate closed");
        i_tcu_pin_model.level(PIN_EXTERNAL_INTERRUPT_PIN_ZERO, 1'b1);
        wait_flag(0, 30, n, v);
        chk(v, 1'b1, "gate open");
        wr(IDX_T01_CONTROL, 8'h00);
        wr(IDX_T01_MODE, 8'h05);
        wr(IDX_T0_LOW, 8'h00);
        wr(IDX_T01_CONTROL, 8'h10);
        repeat (3) i_tcu_pin_model.pulse(PIN_CNT0);
        wr(IDX_T01_CONTROL, 8'h00);
        rd_chk(IDX_T0_LOW, 8'h03);
        $display("gate and counter test done");
        // Split mode: high byte of timer 0 runs on the timer 1 run bit
        k = 1 + rnd() % 20;
        r = rnd();
        wr(IDX_T01_MODE, 8'h33);
        wr(IDX_T1_LOW, r);
        wr(IDX_T1_HIGH, 8'hFF);
        wr(IDX_T0_HIGH, 8'hFF - 8'(k));
        wr(IDX_T01_CONTROL, 8'h40);
        wait_flag(1, 40, n, v);
        chk(16'(n), 16'(k + 1), "split overflow");
        rd_chk(IDX_T1_LOW, r);
        rd_chk(IDX_T0_LOW, 8'h03);
        wr(IDX_T1_LOW, 8'hFF - 8'(k));
        wr(IDX_T01_CONTROL, 8'h40);
        wr(IDX_T01_MODE, 8'h13);
        wait_flag(4, 40, n, v);
        chk(v, 1'b1, "timer 1 restart");
        rd_chk(IDX_T01_CONTROL, 8'h40);
        wr(IDX_T01_CONTROL, 8'h00);
        $display("split test done");
        r = rnd() & 8'h7F;
        q = rnd();
        k = 1 + rnd() % 20;
        wr(IDX_T2_RELOAD_LOW, r);
        wr(IDX_T2_RELOAD_HIGH, q);
        wr(IDX_T2_LOW, 8'hFF - 8'(k));
        wr(IDX_T2_HIGH, 8'hFF);
        wr(IDX_T2_CONTROL, 8'h04);
        wait_flag(2, 40, n, v);
        chk(16'(n), 16'(k + 1), "timer 2 rollover");
        wr(IDX_T2_CONTROL, 8'h80);
        rd_chk(IDX_T2_HIGH, q);
        rd_chk(IDX_T2_CONTROL, 8'h80);
        wr(IDX_T2_CONTROL, 8'h00);
        // Capture, then trigger reload, both counting pin edges only
        r = rnd() & 8'h7F;
        q = rnd();
        wr(IDX_T2_LOW, r);
        wr(IDX_T2_HIGH, q);
        wr(IDX_T2_CONTROL, 8'h0F);
        i_tcu_pin_model.pulse(PIN_TRIG);
        rd_chk(IDX_T2_CONTROL, 8'h4F);
        rd_chk(IDX_T2_RELOAD_LOW, r);
        rd_chk(IDX_T2_RELOAD_HIGH, q);
        repeat (3) i_tcu_pin_model.pulse(PIN_CNT2);
        rd_chk(IDX_T2_LOW, r + 8'h03);
        wr(IDX_T2_CONTROL, 8'h0E);
        wr(IDX_T2_RELOAD_LOW, q);
        wr(IDX_T2_RELOAD_HIGH, r);
        i_tcu_pin_model.pulse(PIN_TRIG);
        rd_chk(IDX_T2_LOW, q);
        rd_chk(IDX_T2_HIGH, r);
        rd_chk(IDX_T2_CONTROL, 8'h4E);
        $display("timer 2 test done");
        for (int b = 0; b < 2; b++)
        begin
            k = 1 + rnd() % 20;
            wr(IDX_T2_LOW, 8'hFF - 8'(k));
            wr(IDX_T2_HIGH, 8'hFF);
            wr(IDX_T2_CONTROL, b ? 8'h2C : 8'h1C);
            wait_flag(5, 40, n, v);
            chk(v, 1'b1, "baud rollover");
            i_tcu_pin_model.pulse(PIN_TRIG);
            rd_chk(IDX_T2_CONTROL, b ? 8'h6C : 8'h5C);
            wr(IDX_T2_CONTROL, 8'h00);
        end
        $display("baud test done");
        give_verdict();
    end
endmodule
